// >>> hdl/wfc_fifo.sv
// Small valid/ready FIFO for readout words
`timescale 1ns/1ps
`default_nettype none
module wfc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0]   count;
	} wfc_fifo_state_type;

	wfc_fifo_state_type s_r;
	wfc_fifo_state_type s_nxt;
	logic [WIDTH-1:0]   mem [DEPTH];
	logic               push;
	logic               pop;

	assign in_ready_out  = (s_r.count != (AW+1)'(DEPTH));
	assign out_valid_out = (s_r.count != '0);
	assign out_data_out  = mem[s_r.rptr];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.wptr = (s_r.wptr == AW'(DEPTH - 1)) ? '0 : s_r.wptr + 1'b1;
		end
		if (pop) begin
			s_nxt.rptr = (s_r.rptr == AW'(DEPTH - 1)) ? '0 : s_r.rptr + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.count = s_r.count + 1'b1;
		end else if (pop && !push) begin
			s_nxt.count = s_r.count - 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[s_r.wptr] <= in_data_in;
		end
	end
endmodule : wfc_fifo
`default_nettype wire

// >>> hdl/wfc_pkg.sv
// Constants and types for the waveform capture register bank
`default_nettype none
package wfc_pkg;
	// ------------------------------------------------------------
	// Register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [11:0] WFC_SIGN_ADDR  = 12'h49D;
	localparam logic [11:0] WFC_CFG_ADDR   = 12'h4A0;
	localparam logic [15:0] WFC_SIGN_RESET = 16'h0000;
	localparam logic [15:0] WFC_CFG_RESET  = 16'h0000;
	localparam logic [15:0] WFC_CFG_WMASK  = 16'h13FF;
	localparam logic [15:0] WFC_SIGN_MASK  = 16'h03FF;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int WFC_NEUT_BIT   = 12;
	localparam int WFC_SRC_LSB    = 8;
	localparam int WFC_MODE_LSB   = 6;
	localparam int WFC_CAPSEL_BIT = 5;
	localparam int WFC_CAPEN_BIT  = 4;
	localparam int WFC_CHSEL_LSB  = 0;
	localparam int WFC_PULSE_LSB  = 6;

	// ------------------------------------------------------------
	// Field codes
	// ------------------------------------------------------------
	localparam logic [1:0] WFC_SRC_LPF   = 2'h2;
	localparam logic [1:0] WFC_SRC_PCF   = 2'h3;
	localparam logic [1:0] WFC_MODE_STOP = 2'h0;
	localparam logic [1:0] WFC_MODE_TRIG = 2'h1;
	localparam logic [1:0] WFC_MODE_CTR  = 2'h2;
	localparam logic [1:0] WFC_MODE_ADDR = 2'h3;
	localparam logic [3:0] WFC_CH_ALL    = 4'h0;
	localparam logic [3:0] WFC_CH_PAIR_A = 4'h1;
	localparam logic [3:0] WFC_CH_PAIR_B = 4'h2;
	localparam logic [3:0] WFC_CH_PAIR_C = 4'h3;
	localparam logic [3:0] WFC_CH_NEUT   = 4'hE;
	localparam logic [3:0] WFC_CH_SINGLE = 4'hF;

	// ------------------------------------------------------------
	// Buffer geometry
	// ------------------------------------------------------------
	localparam int WFC_SW         = 16;
	localparam int WFC_CHANS      = 7;
	localparam int WFC_AW         = 6;
	localparam int WFC_DEPTH      = 64;
	localparam int WFC_FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		WFC_CAP_IDLE = 2'h0,
		WFC_CAP_FILL = 2'h1,
		WFC_CAP_POST = 2'h3,
		WFC_CAP_DONE = 2'h2
	} wfc_cap_type;

	typedef enum logic {
		WFC_RD_IDLE = 1'h0,
		WFC_RD_RUN  = 1'h1
	} wfc_rd_type;
endpackage : wfc_pkg
`default_nettype wire

// >>> hdl/wfc_regs.sv
// Power polarity status and waveform capture configuration bank
`timescale 1ns/1ps
`default_nettype none
module wfc_regs (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [11:0]  reg_addr_in,
	input  wire logic         reg_wr_in,
	input  wire logic         reg_rd_in,
	input  wire logic [15:0]  reg_wdata_in,
	output logic      [15:0]  reg_rdata_out,
	input  wire logic         sign_source_select_in,
	input  wire logic [5:0]   phase_total_sign_in,
	input  wire logic [5:0]   phase_fund_sign_in,
	input  wire logic [5:0]   phase_valid_in,
	input  wire logic [3:0]   pulse_sign_in,
	input  wire logic [3:0]   pulse_valid_in,
	input  wire logic [111:0] lpf_samples_in,
	input  wire logic         lpf_strobe_in,
	input  wire logic [111:0] pcf_samples_in,
	input  wire logic         pcf_strobe_in,
	input  wire logic [111:0] resampled_in,
	input  wire logic         resample_strobe_in,
	input  wire logic         trigger_in,
	output logic              sample_update_strobe_out,
	output logic              capture_active_out,
	output logic              buffer_full_out,
	output logic      [5:0]   trig_addr_out,
	input  wire logic         burst_start_in,
	input  wire logic         burst_stop_in,
	input  wire logic [5:0]   burst_addr_in,
	input  wire logic [2:0]   single_chan_in,
	output logic              rd_valid_out,
	input  wire logic         rd_ready_in,
	output logic      [15:0]  rd_data_out
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// One packed state word; the buffer array stays outside it
	typedef struct packed {
		logic [15:0]         sign;
		logic [15:0]         cfg;
		logic [15:0]         rdata;
		logic                strobe;
		wfc_pkg::wfc_cap_type cap;
		logic [5:0]          wptr;
		logic [5:0]          post;
		logic [5:0]          trig_addr;
		logic                full;
		wfc_pkg::wfc_rd_type rd;
		logic [5:0]          raddr;
		logic [2:0]          rch;
		logic                single;
	} wfc_state_type;

	wfc_state_type s_r;
	wfc_state_type s_nxt;
	logic [111:0]  mem [wfc_pkg::WFC_DEPTH];
	logic [111:0]  mem_word;
	logic [111:0]  cap_data;
	logic          mem_we;
	logic          cap_strobe;
	logic [9:0]    sign_upd;
	logic [9:0]    sign_val;
	logic [9:0]    sign_next;
	logic [6:0]    mask;
	logic          fifo_valid;
	logic          fifo_ready;
	logic [15:0]   fifo_data;
	logic [1:0]    src;
	logic [1:0]    mode;
	logic [3:0]    chsel;
	logic          neut_en;
	logic          cfg_wr;

	assign src     = s_r.cfg[wfc_pkg::WFC_SRC_LSB +: 2];
	assign mode    = s_r.cfg[wfc_pkg::WFC_MODE_LSB +: 2];
	assign chsel   = s_r.cfg[wfc_pkg::WFC_CHSEL_LSB +: 4];
	assign neut_en = s_r.cfg[wfc_pkg::WFC_NEUT_BIT];
	assign cfg_wr  = reg_wr_in && (reg_addr_in == wfc_pkg::WFC_CFG_ADDR);

	// ------------------------------------------------------------
	// Sign refresh, one bit per power result
	// ------------------------------------------------------------
	// A bit holds its last polarity until its own result arrives
	assign sign_upd = {pulse_valid_in, phase_valid_in};
	assign sign_val = {pulse_sign_in,
		sign_source_select_in ? phase_fund_sign_in : phase_total_sign_in};

	for (genvar i = 0; i < 10; i++) begin : g_sign
		assign sign_next[i] = sign_upd[i] ? sign_val[i] : s_r.sign[i];
	end

	// ------------------------------------------------------------
	// Sample source and update strobe
	// ------------------------------------------------------------
	// With the capture select bit set, reserved source codes give no strobe, so nothing is written
	always_comb begin
		cap_strobe = 1'b0;
		cap_data   = resampled_in;
		if (s_r.cfg[wfc_pkg::WFC_CAPSEL_BIT] == 1'b0) begin
			cap_strobe = resample_strobe_in;
		end else begin
			case (src)
				wfc_pkg::WFC_SRC_LPF: begin
					cap_strobe = lpf_strobe_in;
					cap_data   = lpf_samples_in;
				end
				wfc_pkg::WFC_SRC_PCF: begin
					cap_strobe = pcf_strobe_in;
					cap_data   = pcf_samples_in;
				end
				default: begin
					cap_strobe = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Readout channel mask
	// ------------------------------------------------------------
	// Single mode returns the chosen channel; neutral needs its enable
	always_comb begin
		case (chsel)
			wfc_pkg::WFC_CH_ALL:    mask = {neut_en, 6'h3F};
			wfc_pkg::WFC_CH_PAIR_A: mask = 7'h03;
			wfc_pkg::WFC_CH_PAIR_B: mask = 7'h0C;
			wfc_pkg::WFC_CH_PAIR_C: mask = 7'h30;
			4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: begin
				mask = 7'h01 << chsel[2:0];
			end
			wfc_pkg::WFC_CH_NEUT:   mask = {neut_en, 6'h00};
			wfc_pkg::WFC_CH_SINGLE: begin
				mask = 7'h01 << single_chan_in;
				mask[6] = mask[6] & neut_en;
			end
			// Codes 0100 to 0111 return nothing
			default: mask = 7'h00;
		endcase
	end

	assign mem_word  = mem[s_r.raddr];
	assign fifo_data = mem_word[16 * int'(s_r.rch) +: 16];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt      = s_r;
		mem_we     = 1'b0;
		fifo_valid = 1'b0;
		s_nxt.strobe = cap_strobe;
		s_nxt.sign   = {6'h00, sign_next};

		// ------------------------------------------------------------
		// Register port
		// ------------------------------------------------------------
		// Status writes fall through: only the config word is writable
		if (cfg_wr) begin
			s_nxt.cfg = reg_wdata_in & wfc_pkg::WFC_CFG_WMASK;
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				wfc_pkg::WFC_SIGN_ADDR: s_nxt.rdata = s_r.sign & wfc_pkg::WFC_SIGN_MASK;
				wfc_pkg::WFC_CFG_ADDR:  s_nxt.rdata = s_r.cfg;
				default:                s_nxt.rdata = 16'h0000;
			endcase
		end

		// ------------------------------------------------------------
		// Capture sequencer
		// ------------------------------------------------------------
		// One entry per selected strobe; the pointer wraps at the end
		// of the buffer and full stays set until the next start
		case (s_r.cap)
			wfc_pkg::WFC_CAP_FILL: begin
				if (cap_strobe) begin
					mem_we     = 1'b1;
					s_nxt.wptr = s_r.wptr + 6'h01;
					if (s_r.wptr == 6'(wfc_pkg::WFC_DEPTH - 1)) begin
						s_nxt.full = 1'b1;
						if (mode == wfc_pkg::WFC_MODE_STOP) begin
							s_nxt.cap = wfc_pkg::WFC_CAP_DONE;
						end
					end
				end
				// Trigger ignored in stop mode and during the post phase
				if (trigger_in && mode != wfc_pkg::WFC_MODE_STOP) begin
					// Address of the entry written last, this strobe included
					s_nxt.trig_addr = cap_strobe ? s_r.wptr : s_r.wptr - 6'h01;
					case (mode)
						wfc_pkg::WFC_MODE_TRIG: s_nxt.cap = wfc_pkg::WFC_CAP_DONE;
						wfc_pkg::WFC_MODE_CTR: begin
							s_nxt.post = 6'(wfc_pkg::WFC_DEPTH / 2);
							s_nxt.cap  = wfc_pkg::WFC_CAP_POST;
						end
						default: s_nxt.cap = wfc_pkg::WFC_CAP_FILL;
					endcase
				end
			end
			wfc_pkg::WFC_CAP_POST: begin
				// Count down the half buffer written after the trigger
				if (cap_strobe) begin
					mem_we     = 1'b1;
					s_nxt.wptr = s_r.wptr + 6'h01;
					s_nxt.post = s_r.post - 6'h01;
					if (s_r.wptr == 6'(wfc_pkg::WFC_DEPTH - 1)) begin
						s_nxt.full = 1'b1;
					end
					if (s_r.post == 6'h01) begin
						s_nxt.cap = wfc_pkg::WFC_CAP_DONE;
					end
				end
			end
			default: begin
				s_nxt.cap = s_r.cap;
			end
		endcase

		// ------------------------------------------------------------
		// Start and stop of capture
		// ------------------------------------------------------------
		// A start or stop write overrides the sequencer's state, pointer, full flag and write in the same cycle, so a
		// stop never races a strobe into the buffer
		if (cfg_wr && reg_wdata_in[wfc_pkg::WFC_CAPEN_BIT]
			&& !s_r.cfg[wfc_pkg::WFC_CAPEN_BIT]) begin
			s_nxt.cap       = wfc_pkg::WFC_CAP_FILL;
			s_nxt.wptr      = 6'h00;
			s_nxt.full      = 1'b0;
			s_nxt.trig_addr = 6'h00;
			mem_we          = 1'b0;
		end else if (cfg_wr && !reg_wdata_in[wfc_pkg::WFC_CAPEN_BIT]) begin
			s_nxt.cap  = wfc_pkg::WFC_CAP_IDLE;
			s_nxt.wptr = s_r.wptr;
			s_nxt.full = s_r.full;
			s_nxt.post = s_r.post;
			mem_we     = 1'b0;
		end

		// ------------------------------------------------------------
		// Readout engine
		// ------------------------------------------------------------
		// Masked channels are skipped without a push; a full FIFO stalls
		// the walk on the channel it holds, so no word is lost
		case (s_r.rd)
			wfc_pkg::WFC_RD_IDLE: begin
				// Channel and entry are latched once per burst
				if (burst_start_in) begin
					s_nxt.rd     = wfc_pkg::WFC_RD_RUN;
					s_nxt.raddr  = burst_addr_in;
					s_nxt.single = (chsel == wfc_pkg::WFC_CH_SINGLE);
					s_nxt.rch    = (chsel == wfc_pkg::WFC_CH_SINGLE) ? single_chan_in : 3'h0;
				end
			end
			wfc_pkg::WFC_RD_RUN: begin
				if (burst_stop_in || mask == 7'h00) begin
					s_nxt.rd = wfc_pkg::WFC_RD_IDLE;
				end else if (!mask[s_r.rch] || fifo_ready) begin
					fifo_valid = mask[s_r.rch];
					if (s_r.single) begin
						s_nxt.rd = wfc_pkg::WFC_RD_IDLE;
					end else if (s_r.rch == 3'(wfc_pkg::WFC_CHANS - 1)) begin
						s_nxt.rch   = 3'h0;
						s_nxt.raddr = s_r.raddr + 6'h01;
					end else begin
						s_nxt.rch = s_r.rch + 3'h1;
					end
				end
			end
			default: begin
				s_nxt.rd = wfc_pkg::WFC_RD_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers and buffer memory
	// ------------------------------------------------------------
	// Buffer memory has no reset; a stop leaves its contents alone
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r      <= '0;
			s_r.sign <= wfc_pkg::WFC_SIGN_RESET;
			s_r.cfg  <= wfc_pkg::WFC_CFG_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[s_r.wptr] <= cap_data;
		end
	end

	// ------------------------------------------------------------
	// Readout FIFO and outputs
	// ------------------------------------------------------------
	// Readout words queue here so a slow host never loses one
	wfc_fifo #(
		.WIDTH(wfc_pkg::WFC_SW),
		.DEPTH(wfc_pkg::WFC_FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.in_valid_in  (fifo_valid),
		.in_ready_out (fifo_ready),
		.in_data_in   (fifo_data),
		.out_valid_out(rd_valid_out),
		.out_ready_in (rd_ready_in),
		.out_data_out (rd_data_out)
	);

	assign reg_rdata_out            = s_r.rdata;
	assign sample_update_strobe_out = s_r.strobe;
	assign capture_active_out       = (s_r.cap == wfc_pkg::WFC_CAP_FILL)
		|| (s_r.cap == wfc_pkg::WFC_CAP_POST);
	assign buffer_full_out          = s_r.full;
	assign trig_addr_out            = s_r.trig_addr;
endmodule : wfc_regs
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the waveform capture register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [11:0] SA = wfc_pkg::WFC_SIGN_ADDR;
	localparam logic [11:0] CA = wfc_pkg::WFC_CFG_ADDR;
	logic         clk_in, rst_in, wr, rd, sel, lstb, pstb, trig, bstart, bstop, stall;
	logic [11:0]  addr;
	logic [15:0]  wdata, rdata, rv, rdat;
	logic [5:0]   tsg, fsg, pval, baddr, taddr;
	logic [3:0]   psg, pvl;
	logic [111:0] lpf, pcf, s, rsmp;
	logic [2:0]   schan;
	logic         upd, active, full, rvalid, rready, rstb;
	logic [9:0]   sh;
	logic [4:0]   tbl[7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h10};
	int           error_cnt, samples_checked, seed_v;

	wfc_regs dut_u (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.sign_source_select_in(sel), .phase_total_sign_in(tsg), .phase_fund_sign_in(fsg),
		.phase_valid_in(pval), .pulse_sign_in(psg), .pulse_valid_in(pvl),
		.lpf_samples_in(lpf), .lpf_strobe_in(lstb), .pcf_samples_in(pcf),
		.pcf_strobe_in(pstb), .resampled_in(rsmp), .resample_strobe_in(rstb),
		.trigger_in(trig), .sample_update_strobe_out(upd), .capture_active_out(active),
		.buffer_full_out(full), .trig_addr_out(taddr), .burst_start_in(bstart),
		.burst_stop_in(bstop), .burst_addr_in(baddr), .single_chan_in(schan),
		.rd_valid_out(rvalid), .rd_ready_in(rready), .rd_data_out(rdat));
	wfc_sink sink_u (.clk_in(clk_in), .rst_in(rst_in), .valid_in(rvalid),
		.data_in(rdat), .stall_in(stall), .ready_out(rready));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cyc(input int n = 1);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic wreg(input logic [11:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc();
		wr = 1'b0;
		cyc();
	endtask : wreg

	task automatic rreg(input logic [11:0] a);
		addr = a;
		rd = 1'b1;
		cyc();
		rd = 1'b0;
		rv = rdata;
		cyc();
	endtask : rreg

	task automatic done(input string n);
		$display("test %s done", n);
	endtask : done

	function automatic logic [111:0] smp(input int k);
		for (int c = 0; c < 7; c++) smp[c*16 +: 16] = {4'hA, 4'(c), 8'(k)};
	endfunction : smp

	function automatic logic [6:0] msk(input logic [4:0] t);
		case (t[3:0])
			4'h0: msk = t[4] ? 7'h7F : 7'h3F;
			4'h1: msk = 7'h03;
			4'h2: msk = 7'h0C;
			4'h3: msk = 7'h30;
			4'h8: msk = 7'h01;
			default: msk = 7'h02;
		endcase
	endfunction : msk

	// Burst from entry a, sink stalled first so readout words queue in the FIFO
	task automatic burst(input logic [5:0] a, input logic [6:0] m, input int off, input int n);
		logic [15:0]  e[$];
		logic [111:0] x;
		sink_u.got_q.delete();
		stall = 1'b1;
		baddr = a;
		bstart = 1'b1;
		cyc();
		bstart = 1'b0;
		cyc(20);
		chk16({15'h0, rvalid}, 16'h0001);
		stall = 1'b0;
		for (int i = 0; i < 400 && sink_u.got_q.size() < n; i++) cyc();
		bstop = 1'b1;
		cyc();
		bstop = 1'b0;
		cyc(20);
		for (int j = 0; e.size() < n; j++) begin
			x = smp((a + j / 7) % 64 + off);
			if (m[j % 7]) e.push_back(x[(j % 7) * 16 +: 16]);
		end
		for (int i = 0; i < n; i++) chk16(sink_u.got_q[i], e[i]);
	endtask : burst

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Clock, watchdog, tests
	// ------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	initial begin
		#1000000;
		error_cnt++;
		close_out();
	end

	initial begin
		{wr, rd, sel, lstb, pstb, trig, bstart, bstop, stall, addr, wdata} = '0;
		{tsg, fsg, pval, baddr, psg, pvl, lpf, pcf, schan, rsmp, rstb} = '0;
		rst_in = 1'b1;
		seed_v = $urandom(88647);
		cyc(3);
		rst_in = 1'b0;
		rreg(SA);
		chk16(rv, wfc_pkg::WFC_SIGN_RESET);
		rreg(CA);
		chk16(rv, wfc_pkg::WFC_CFG_RESET);
		rreg(12'h4A1);
		chk16(rv, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wdata = 16'($urandom) & 16'hFFEF;
			wreg(CA, wdata);
			rreg(CA);
			chk16(rv, wdata & wfc_pkg::WFC_CFG_WMASK);
		end
		wreg(CA, 16'h0000);
		done("registers");
		sh = '0;
		for (int i = 0; i < 20; i++) begin
			{sel, tsg, fsg, pval} = 19'($urandom);
			{psg, pvl} = 8'($urandom);
			cyc();
			for (int b = 0; b < 6; b++) if (pval[b]) sh[b] = sel ? fsg[b] : tsg[b];
			for (int b = 0; b < 4; b++) if (pvl[b]) sh[6 + b] = psg[b];
			{pval, pvl} = '0;
			wreg(SA, 16'($urandom));
			rreg(SA);
			chk16(rv, {6'h00, sh});
		end
		done("signs");
		wreg(CA, 16'h0230);
		chk16({15'h0, active}, 16'h0001);
		for (int k = 0; k < 70; k++) begin
			lpf = smp(k);
			pcf = smp(k + 200);
			lstb = 1'b1;
			cyc();
			if (k == 0) chk16({15'h0, upd}, 16'h0001);
			lstb = 1'b0;
			pstb = 1'b1;
			cyc();
			if (k == 0) chk16({15'h0, upd}, 16'h0000);
			pstb = 1'b0;
		end
		chk16({14'h0, full, active}, 16'h0002);
		for (int t = 0; t < 7; t++) begin
			wreg(CA, {3'h0, tbl[t][4], 8'h23, tbl[t][3:0]});
			burst(6'($urandom), msk(tbl[t]), 0, 12);
		end
		wreg(CA, 16'h023F);
		schan = 3'($urandom % 6);
		baddr = 6'($urandom);
		sink_u.got_q.delete();
		bstart = 1'b1;
		cyc();
		bstart = 1'b0;
		cyc(20);
		s = smp(baddr);
		chk16(16'(sink_u.got_q.size()), 16'h0001);
		chk16(sink_u.got_q[0], s[schan*16 +: 16]);
		done("capture and readout");
		wreg(CA, 16'h0000);
		chk16({15'h0, active}, 16'h0000);
		wreg(CA, 16'h03F1);
		for (int k = 0; k < 5; k++) begin
			pcf = smp(k + 100);
			pstb = 1'b1;
			cyc();
		end
		pstb = 1'b0;
		trig = 1'b1;
		cyc();
		trig = 1'b0;
		cyc(2);
		chk16({9'h0, active, taddr}, 16'h0044);
		wreg(CA, 16'h0321);
		chk16({15'h0, active}, 16'h0000);
		pcf = smp(300);
		pstb = 1'b1;
		cyc(3);
		pstb = 1'b0;
		burst(6'h00, msk(5'h01), 100, 4);
		wreg(CA, 16'h0310);
		for (int k = 0; k < 3; k++) begin
			rsmp = smp(k + 50);
			pcf = smp(k + 150);
			{rstb, pstb} = 2'h3;
			cyc();
		end
		{rstb, pstb} = 2'h0;
		wreg(CA, 16'h0301);
		burst(6'h00, msk(5'h01), 50, 4);
		wreg(CA, 16'h0000);
		wreg(CA, 16'h0370);
		pstb = 1'b1;
		cyc(3);
		chk16({15'h0, active}, 16'h0001);
		trig = 1'b1;
		cyc();
		trig = 1'b0;
		cyc(2);
		chk16({15'h0, active}, 16'h0000);
		pstb = 1'b0;
		wreg(CA, 16'h0000);
		wreg(CA, 16'h02B0);
		lstb = 1'b1;
		cyc(5);
		trig = 1'b1;
		cyc();
		trig = 1'b0;
		cyc(31);
		chk16({15'h0, active}, 16'h0001);
		cyc();
		chk16({15'h0, active}, 16'h0000);
		lstb = 1'b0;
		done("trigger modes");
		rst_in = 1'b1;
		cyc(3);
		rst_in = 1'b0;
		rreg(SA);
		chk16(rv, wfc_pkg::WFC_SIGN_RESET);
		rreg(CA);
		chk16(rv, wfc_pkg::WFC_CFG_RESET);
		done("reset");
		close_out();
	end
endmodule : tb_top
`default_nettype wire

// >>> test/wfc_regs_chk.sv
// Port checker for the waveform capture register bank
`timescale 1ns/1ps
`default_nettype none
module wfc_regs_chk (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        lpf_strobe_in,
	input wire logic        pcf_strobe_in,
	input wire logic        resample_strobe_in,
	input wire logic        trigger_in,
	input wire logic        sample_update_strobe_out,
	input wire logic        capture_active_out,
	input wire logic [5:0]  trig_addr_out,
	input wire logic        rd_valid_out,
	input wire logic        rd_ready_in,
	input wire logic [15:0] rd_data_out
);
	localparam logic [11:0] SA = wfc_pkg::WFC_SIGN_ADDR;
	localparam logic [11:0] CA = wfc_pkg::WFC_CFG_ADDR;
	logic                   en_r;

	// Last written capture enable, to tell a start from a rewrite
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			en_r <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == CA) begin
			en_r <= reg_wdata_in[wfc_pkg::WFC_CAPEN_BIT];
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_rd_unmapped: assert property (
		reg_rd_in && reg_addr_in != SA && reg_addr_in != CA |=> reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	a_cfg_mask: assert property (
		reg_rd_in && reg_addr_in == CA |=> (reg_rdata_out & ~wfc_pkg::WFC_CFG_WMASK) == 16'h0000)
		else $error("config reserved bits set");
	a_sign_reserved: assert property (
		reg_rd_in && reg_addr_in == SA |=> reg_rdata_out[15:10] == 6'h00)
		else $error("status reserved bits set");
	a_rdata_hold: assert property (
		!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without read");
	a_strobe_cause: assert property (
		sample_update_strobe_out |-> $past(lpf_strobe_in || pcf_strobe_in || resample_strobe_in))
		else $error("update strobe without source strobe");
	a_cap_stop: assert property (
		reg_wr_in && reg_addr_in == CA && !reg_wdata_in[4] |=> !capture_active_out)
		else $error("capture still active after disable");
	a_pop_hold: assert property (
		rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out))
		else $error("readout word dropped while stalled");
	a_trig_hold: assert property (
		!trigger_in
		&& !(reg_wr_in && reg_addr_in == CA && reg_wdata_in[wfc_pkg::WFC_CAPEN_BIT] && !en_r)
		|=> $stable(trig_addr_out))
		else $error("trigger address moved without trigger");
	a_cap_start: assert property (
		reg_wr_in && reg_addr_in == CA && reg_wdata_in[wfc_pkg::WFC_CAPEN_BIT] && !en_r
		|=> capture_active_out)
		else $error("capture not started by enable edge");
endmodule : wfc_regs_chk

bind wfc_regs wfc_regs_chk chk_u (.clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
	.reg_wdata_in, .reg_rdata_out, .lpf_strobe_in, .pcf_strobe_in, .resample_strobe_in,
	.trigger_in, .sample_update_strobe_out, .capture_active_out, .trig_addr_out,
	.rd_valid_out, .rd_ready_in, .rd_data_out);
`default_nettype wire

// >>> test/wfc_sink.sv
// Readout sink draining the capture FIFO with random stalls
`timescale 1ns/1ps
`default_nettype none
module wfc_sink (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        valid_in,
	input  wire logic [15:0] data_in,
	input  wire logic        stall_in,
	output var  logic        ready_out
);
	logic [15:0] got_q[$];
	initial ready_out = 1'b0;
	always @(posedge clk_in) begin
		if (!rst_in && valid_in && ready_out) begin
			got_q.push_back(data_in);
		end
		#1 ready_out <= !stall_in && ($urandom % 4 != 0);
	end
endmodule : wfc_sink
`default_nettype wire
